//--- hw/perf_feac_core.sv
// Receive performance counters and alarm channel transmit control
// Behaviour
// - Each counter is read-only, 8 bits, stops at 255, clears when read.
// - Indications during read or increment are held, giving one later increment.
// - Parity mode: counter 02 counts frames with any C10-C12 bit zero.
// - Legacy mode: counter 02 counts each F-bit error.
// - Legacy mode: counters 02 and 03 freeze during loss of signal or frame.
// - Parity mode: counter 03 counts frames with majority C-bit parity mismatch.
// - Parity mode: each C-bit parity error sends a far error report unless disabled.
// - Legacy mode: counter 03 counts received frames.
// - Counter 04 counts frames with P1 or P2 parity mismatch.
// - P-bit parity errors never send a far error report.
// - Counter 04 freezes during loss of signal or frame in both modes.
// - Bit 7 of 05 enables the extended controls above 07H.
// - Start bit 6 of 05 repeats the 16-bit alarm word in C3.
// - Ten-repeat option set with bit 7 of 05 set: send word 10 times, then clear start.
// - Option clear: after start clears send 10 more words, then C3 idles one.
// - Word is 0, message bits 5..0, 0, then eight ones.
// - Bit 7 of 01 suppresses far error reports.
// - Bit 3 of 01 picks legacy mode when one, parity mode when zero.
`timescale 1ns/1ps
`default_nettype none
`include "perf_feac_defines.svh"
module perf_feac_core (
    input wire logic clk_i,                          // 200 MHz clock
    input wire logic arst_n_i,                       // Async reset, active low
    input wire logic [`ADDR_W-1:0] addr_i,           // Register address
    input wire logic rd_en_i,                        // Read strobe, one cycle
    input wire logic wr_en_i,                        // Write strobe, one cycle
    input wire logic [`DATA_W-1:0] wdata_i,          // Write data
    output logic [`DATA_W-1:0] rdata_o,              // Read data, valid cycle after strobe
    input wire logic legacy_multiplex_mode_select_i, // Legacy mode when high
    input wire logic far_error_report_disable_i,     // Suppress far error reports
    input wire logic ten_repeat_option_i,            // Send alarm word exactly 10 times when extended controls are enabled
    input wire logic frame_i,                        // Received frame pulse
    input wire logic far_error_ind_i,                // Frame with a C10-C12 zero, pulse
    input wire logic fbit_err_i,                     // F-bit error, pulse
    input wire logic cpar_err_i,                     // C-bit parity majority error, pulse
    input wire logic ppar_err_i,                     // P-bit parity error, pulse
    input wire logic los_i,                          // Loss of signal, level
    input wire logic oof_i,                          // Out of frame, level
    input wire logic c3_slot_i,                      // Transmit C3 bit slot, pulse
    output logic c3_bit_o,                           // Transmit C3 bit value
    output logic far_error_tx_o,                     // Far error report request, pulse
    output logic extended_features_enable_o          // Extended controls enabled
);
    import perf_feac_pkg::*;

    localparam logic [3:0] LAST_REP = 4'(`FEAC_REPEATS - 1);
    localparam logic [`DATA_W-1:0] RST_CTRL = `RST_ALARM_TX_CTRL;

    logic [`DATA_W-1:0] far_err_count;
    logic [`DATA_W-1:0] parity_frame_count;
    logic [`DATA_W-1:0] path_parity_count;
    logic extended_features_enable;
    logic start_bit;
    logic [`MSG_W-1:0] feac_msg;
    feac_state_e state;
    logic [3:0] bit_idx;
    logic [3:0] rep;
    logic tail_skip;
    logic [`FEAC_WORD_W-1:0] word_sr;
    logic [`FEAC_WORD_W-1:0] fresh_word;
    logic signal_lost;
    logic legacy_hold;
    logic ten_eff;
    logic word_done;
    logic hw_start_clr;
    logic rd_far, rd_pf, rd_pp;
    logic wr_ctrl;
    logic [3:0] next_bit_idx;
    logic fe_evt, pf_evt;

    function automatic logic [`FEAC_WORD_W-1:0] feac_word(input logic [`MSG_W-1:0] m);
        feac_word = {1'b0, m, 1'b0, `FEAC_TRAIL_ONES};
    endfunction

    assign fresh_word = feac_word(feac_msg);

    assign signal_lost = los_i | oof_i;
    assign legacy_hold = legacy_multiplex_mode_select_i & signal_lost;
    assign rd_far = rd_en_i && addr_i == `OFF_FAR_ERR_CNT;
    assign rd_pf = rd_en_i && addr_i == `OFF_PARITY_FRAME_CNT;
    assign rd_pp = rd_en_i && addr_i == `OFF_PATH_PARITY_CNT;
    assign wr_ctrl = wr_en_i && addr_i == `OFF_ALARM_TX_CTRL;
    // Option register sits above 07H, so it only acts in extended mode
    assign ten_eff = ten_repeat_option_i & extended_features_enable;
    assign word_done = c3_slot_i && state != CH_IDLE && bit_idx == 4'hf;
    assign next_bit_idx = (c3_slot_i && state != CH_IDLE) ? bit_idx + 4'h1 : bit_idx;
    assign hw_start_clr = state == CH_SEND && ten_eff && word_done && rep == LAST_REP;

    // Counter meaning follows the mode select
    assign fe_evt = legacy_multiplex_mode_select_i ? fbit_err_i : far_error_ind_i;
    assign pf_evt = legacy_multiplex_mode_select_i ? frame_i : cpar_err_i;

    sat_clr_counter #(.WIDTH(`DATA_W)) u_far_err (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .evt_i(fe_evt),
        .hold_i(legacy_hold),
        .clr_i(rd_far),
        .count_o(far_err_count)
    );

    sat_clr_counter #(.WIDTH(`DATA_W)) u_parity_frame (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .evt_i(pf_evt),
        .hold_i(legacy_hold),
        .clr_i(rd_pf),
        .count_o(parity_frame_count)
    );

    sat_clr_counter #(.WIDTH(`DATA_W)) u_path_parity (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .evt_i(ppar_err_i),
        .hold_i(signal_lost),
        .clr_i(rd_pp),
        .count_o(path_parity_count)
    );

    // Read data captured on the read edge, before the clear lands
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else if (rd_en_i) begin
            unique case (addr_i)
                `OFF_FAR_ERR_CNT: rdata_o <= far_err_count;
                `OFF_PARITY_FRAME_CNT: rdata_o <= parity_frame_count;
                `OFF_PATH_PARITY_CNT: rdata_o <= path_parity_count;
                `OFF_ALARM_TX_CTRL: rdata_o <= {extended_features_enable, start_bit, feac_msg};
                default: rdata_o <= '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            extended_features_enable <= RST_CTRL[`BIT_EXT_ENABLE];
            feac_msg <= RST_CTRL[`MSG_MSB:0];
        end else if (wr_ctrl) begin
            extended_features_enable <= wdata_i[`BIT_EXT_ENABLE];
            feac_msg <= wdata_i[`MSG_MSB:0];
        end
    end

    // A software write of the start bit wins over the automatic clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_bit <= 1'b0;
        end else if (wr_ctrl) begin
            start_bit <= wdata_i[`BIT_START];
        end else if (hw_start_clr) begin
            start_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            extended_features_enable_o <= 1'b0;
        end else begin
            extended_features_enable_o <= extended_features_enable;
        end
    end

    // P-bit parity errors never reach the transmit report path
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            far_error_tx_o <= 1'b0;
        end else begin
            far_error_tx_o <= !far_error_report_disable_i &&
                ((cpar_err_i && !legacy_multiplex_mode_select_i) || fbit_err_i);
        end
    end

    // Alarm channel sequencer; words always finish, state changes only count whole words
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= CH_IDLE;
            rep <= 4'h0;
            tail_skip <= 1'b0;
        end else begin
            unique case (state)
                CH_IDLE: begin
                    rep <= 4'h0;
                    tail_skip <= 1'b0;
                    if (start_bit) begin
                        state <= CH_SEND;
                    end
                end
                CH_SEND: begin
                    if (hw_start_clr) begin
                        state <= CH_IDLE;
                    end else if (!start_bit) begin
                        state <= CH_TAIL;
                        rep <= 4'h0;
                        tail_skip <= next_bit_idx != 4'h0;
                    end else if (word_done) begin
                        rep <= rep + 4'h1;
                    end
                end
                CH_TAIL: begin
                    if (word_done) begin
                        if (tail_skip) begin
                            tail_skip <= 1'b0;
                        end else if (rep == LAST_REP) begin
                            state <= CH_IDLE;
                        end else begin
                            rep <= rep + 4'h1;
                        end
                    end
                end
                default: state <= CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_idx <= 4'h0;
            word_sr <= '1;
            c3_bit_o <= 1'b1;
        end else if (c3_slot_i) begin
            if (state == CH_IDLE) begin
                bit_idx <= 4'h0;
                c3_bit_o <= 1'b1;
            end else if (bit_idx == 4'h0) begin
                bit_idx <= next_bit_idx;
                word_sr <= fresh_word << 1;
                c3_bit_o <= fresh_word[`FEAC_WORD_W-1];
            end else begin
                bit_idx <= next_bit_idx;
                word_sr <= word_sr << 1;
                c3_bit_o <= word_sr[`FEAC_WORD_W-1];
            end
        end
    end

    chk_read_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_far |=> far_err_count == 8'h00)
        else $error("read did not clear counter 02");
    chk_read_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_pp |=> rdata_o == $past(path_parity_count))
        else $error("read did not return pre-clear count");
    chk_legacy_freeze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        legacy_hold && !rd_pf |=> $stable(parity_frame_count))
        else $error("legacy counter moved during loss");
    chk_path_freeze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        signal_lost && !rd_pp |=> $stable(path_parity_count))
        else $error("P-bit counter moved during loss");
    chk_frame_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        legacy_multiplex_mode_select_i && frame_i && !signal_lost && !rd_pf &&
        parity_frame_count == 8'h00 |=> parity_frame_count == 8'h01)
        else $error("frame not counted in legacy mode");
    chk_report_sent: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cpar_err_i && !legacy_multiplex_mode_select_i && !far_error_report_disable_i |=> far_error_tx_o)
        else $error("parity error gave no far error report");
    chk_report_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        far_error_report_disable_i |=> !far_error_tx_o)
        else $error("report sent while disabled");
    chk_ppar_silent: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ppar_err_i && !cpar_err_i && !fbit_err_i |=> !far_error_tx_o)
        else $error("P-bit error produced a report");
    chk_word_frame: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        c3_slot_i && state != CH_IDLE && (bit_idx == 4'h0 || bit_idx == 4'h7) |=> !c3_bit_o)
        else $error("alarm word framing zero missing");
    chk_idle_ones: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        c3_slot_i && state == CH_IDLE |=> c3_bit_o)
        else $error("idle channel not sending one");
    chk_ten_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        hw_start_clr && !wr_ctrl |=> !start_bit && state == CH_IDLE)
        else $error("start not cleared after ten words");
    chk_send_begin: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CH_IDLE && start_bit |=> state == CH_SEND)
        else $error("start did not begin sending");

    cov_saturate: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        far_err_count == 8'hff ##1 rd_far);
    cov_ten_done: cover property (@(posedge clk_i) disable iff (!arst_n_i) hw_start_clr);
    cov_tail_done: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CH_TAIL ##1 state == CH_IDLE);
endmodule
`default_nettype wire

//--- hw/sat_clr_counter.sv
// Saturating clear-on-read event counter with a one-deep held indication
`timescale 1ns/1ps
`default_nettype none
module sat_clr_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,                // System clock
    input wire logic arst_n_i,             // Async reset, active low
    input wire logic evt_i,                // Count indication, one-cycle pulse
    input wire logic hold_i,               // Freeze counting while high
    input wire logic clr_i,                // Read strobe, clears the count
    output logic [WIDTH-1:0] count_o       // Current count
);
    logic pending;

    function automatic logic [WIDTH-1:0] sat_inc(input logic [WIDTH-1:0] v);
        sat_inc = (&v) ? v : v + WIDTH'(1);
    endfunction

    // Indications seen during a read or an increment merge into one later step
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending <= 1'b0;
        end else if (clr_i || hold_i) begin
            // A frozen counter drops indications outright, so nothing seen in a fault is counted later
            pending <= pending | (evt_i & !hold_i);
        end else if (pending) begin
            pending <= evt_i;
        end else begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= '0;
        end else if (clr_i) begin
            count_o <= '0;
        end else if (!hold_i && (evt_i || pending)) begin
            count_o <= sat_inc(count_o);
        end
    end

    chk_sat_stays: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (&count_o) && !clr_i |=> (&count_o))
        else $error("counter left saturation without a read");
    chk_held_single: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (clr_i && evt_i && !hold_i) ##1 (!clr_i && !hold_i && !evt_i) |=> count_o == WIDTH'(1))
        else $error("held indication not counted exactly once");
    chk_hold_stable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        hold_i && !clr_i |=> $stable(count_o))
        else $error("counter moved while held");
endmodule
`default_nettype wire

//--- shared/perf_feac_defines.svh
// Register offsets, field positions, reset values and counts for the counters and alarm channel
`ifndef PERF_FEAC_DEFINES_SVH
`define PERF_FEAC_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 8
`define OFF_FAR_ERR_CNT 8'h02
`define OFF_PARITY_FRAME_CNT 8'h03
`define OFF_PATH_PARITY_CNT 8'h04
`define OFF_ALARM_TX_CTRL 8'h05
`define BIT_EXT_ENABLE 7
`define BIT_START 6
`define MSG_MSB 5
`define MSG_W 6
`define RST_ALARM_TX_CTRL 8'h00
`define RST_COUNT 8'h00
`define FEAC_WORD_W 16
`define FEAC_REPEATS 10
`define FEAC_TRAIL_ONES 8'hff

`endif

//--- shared/perf_feac_pkg.sv
// Types shared by the performance counter and alarm channel logic
package perf_feac_pkg;
    typedef enum logic [2:0] {
        CH_IDLE = 3'b001,
        CH_SEND = 3'b010,
        CH_TAIL = 3'b100
    } feac_state_e;
endpackage

//--- testbench/ds3_line_model.sv
// Line side model: receive event pulses, fault levels and a sampler for transmit C3 slots
`timescale 1ns/1ps
`default_nettype none
module ds3_line_model (
    input wire logic clk_i,           // System clock
    input wire logic c3_bit_i,        // Transmit C3 bit from the block
    input wire logic far_error_tx_i,  // Far error report request from the block
    output logic frame_o,             // Received frame pulse
    output logic far_error_ind_o,     // Frame with a C10-C12 zero
    output logic fbit_err_o,          // F-bit error
    output logic cpar_err_o,          // C-bit parity error
    output logic ppar_err_o,          // P-bit parity error
    output logic los_o,               // Loss of signal level
    output logic oof_o,               // Out of frame level
    output logic c3_slot_o            // Transmit C3 slot pulse
);
    logic [4:0] evt = 5'h00;
    logic [7:0] tx_reports = 8'h00;
    logic c3_bits [$];
    assign {ppar_err_o, cpar_err_o, fbit_err_o, far_error_ind_o, frame_o} = evt;
    initial begin
        los_o = 1'b0;
        oof_o = 1'b0;
        c3_slot_o = 1'b0;
    end
    // Counts report requests seen on the transmit side
    always @(posedge clk_i) begin
        if (far_error_tx_i === 1'b1) begin
            tx_reports <= tx_reports + 8'h01;
        end
    end
    // Kind: 0 frame, 1 far error, 2 F-bit, 3 C-bit parity, 4 P-bit parity
    task automatic pulse(input int kind, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            evt[kind] = 1'b1;
            @(negedge clk_i);
            evt[kind] = 1'b0;
            repeat (gap) @(negedge clk_i);
        end
    endtask
    task automatic set_fault(input logic los, input logic oof);
        @(negedge clk_i);
        los_o = los;
        oof_o = oof;
    endtask
    // Slots are spaced three cycles apart; the bit is taken once the slot edge has landed
    task automatic slots(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            c3_slot_o = 1'b1;
            @(negedge clk_i);
            c3_slot_o = 1'b0;
            c3_bits.push_back(c3_bit_i);
            @(negedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/perf_feac_core_tb_top.sv
// Self-checking bench for the performance counters and alarm channel
`timescale 1ns/1ps
`default_nettype none
`include "perf_feac_defines.svh"
module perf_feac_core_tb_top;
    logic clk_i, arst_n_i, rd_en_i, wr_en_i, mode, no_report, ten_rep;
    logic [`ADDR_W-1:0] addr_i;
    logic [`DATA_W-1:0] wdata_i, rdata_o, d;
    logic frame, fei, fbe, cpe, ppe, los, oof, slot, c3_bit, report_tx, ext_en;
    int mismatches = 0;
    int total_checks = 0;
    logic [7:0] rep0;
    perf_feac_core i_perf_feac_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .rd_en_i(rd_en_i),
        .wr_en_i(wr_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .legacy_multiplex_mode_select_i(mode),
        .far_error_report_disable_i(no_report), .ten_repeat_option_i(ten_rep), .frame_i(frame),
        .far_error_ind_i(fei), .fbit_err_i(fbe), .cpar_err_i(cpe), .ppar_err_i(ppe), .los_i(los), .oof_i(oof),
        .c3_slot_i(slot), .c3_bit_o(c3_bit), .far_error_tx_o(report_tx), .extended_features_enable_o(ext_en));
    ds3_line_model i_ds3_line_model (.clk_i(clk_i), .c3_bit_i(c3_bit), .far_error_tx_i(report_tx),
        .frame_o(frame), .far_error_ind_o(fei), .fbit_err_o(fbe), .cpar_err_o(cpe), .ppar_err_o(ppe),
        .los_o(los), .oof_o(oof), .c3_slot_o(slot));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic do_reset;
        @(negedge clk_i);
        arst_n_i = 1'b0;
        repeat (10) @(negedge clk_i);
        arst_n_i = 1'b1;
        @(negedge clk_i);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_i);
        addr_i = a;
        rd_en_i = 1'b1;
        @(negedge clk_i);
        rd_en_i = 1'b0;
        v = rdata_o;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = v;
        wr_en_i = 1'b1;
        @(negedge clk_i);
        wr_en_i = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] v;
        reg_rd(a, v);
        check(name, v, exp);
    endtask
    // Words go out MSB first: zero, six message bits, zero, eight ones; idle slots carry one
    task automatic check_words(input logic [5:0] msg, input int nw, input int total);
        logic [15:0] w, e;
        check("c3_bit_count", 8'(i_ds3_line_model.c3_bits.size() / 16), 8'(total));
        for (int k = 0; k < total; k++) begin
            e = (k < nw) ? {1'b0, msg, 1'b0, `FEAC_TRAIL_ONES} : 16'hffff;
            for (int b = 0; b < 16; b++) begin
                w[15 - b] = i_ds3_line_model.c3_bits[16 * k + b];
            end
            check("c3_word_hi", w[15:8], e[15:8]);
            check("c3_word_lo", w[7:0], e[7:0]);
        end
        i_ds3_line_model.c3_bits.delete();
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        final_report;
    end
    initial begin
        {arst_n_i, rd_en_i, wr_en_i, mode, no_report, ten_rep} = 6'h00;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        do_reset;
        rd_chk(`OFF_FAR_ERR_CNT, `RST_COUNT, "cnt02");
        rd_chk(`OFF_PARITY_FRAME_CNT, `RST_COUNT, "cnt03");
        rd_chk(`OFF_PATH_PARITY_CNT, `RST_COUNT, "cnt04");
        rd_chk(`OFF_ALARM_TX_CTRL, `RST_ALARM_TX_CTRL, "ctrl05");
        reg_wr(`OFF_FAR_ERR_CNT, 8'h5a);
        rd_chk(8'h07, 8'h00, "unmapped07");
        rd_chk(`OFF_FAR_ERR_CNT, `RST_COUNT, "cnt02_ro");
        $display("test reset_values done");
        // Parity mode: frames and F-bit errors stay out of counters 02 and 03
        i_ds3_line_model.pulse(0, 2, 1);
        i_ds3_line_model.pulse(1, 3, 1);
        i_ds3_line_model.pulse(2, 2, 1);
        i_ds3_line_model.pulse(3, 2, 1);
        i_ds3_line_model.pulse(4, 1, 2);
        rd_chk(`OFF_FAR_ERR_CNT, 8'h03, "cnt02");
        rd_chk(`OFF_FAR_ERR_CNT, 8'h00, "cnt02_cleared");
        rd_chk(`OFF_PARITY_FRAME_CNT, 8'h02, "cnt03");
        rd_chk(`OFF_PATH_PARITY_CNT, 8'h01, "cnt04");
        check("reports", i_ds3_line_model.tx_reports, 8'h04);
        no_report = 1'b1;
        i_ds3_line_model.pulse(3, 1, 1);
        i_ds3_line_model.pulse(2, 1, 2);
        check("reports_off", i_ds3_line_model.tx_reports, 8'h04);
        no_report = 1'b0;
        // An indication landing on the read edge must survive the clear
        i_ds3_line_model.pulse(1, 1, 1);
        fork
            reg_rd(`OFF_FAR_ERR_CNT, d);
            i_ds3_line_model.pulse(1, 1, 0);
        join
        check("cnt02_on_read", d, 8'h01);
        rd_chk(`OFF_FAR_ERR_CNT, 8'h01, "cnt02_held");
        i_ds3_line_model.set_fault(1'b0, 1'b1);
        i_ds3_line_model.pulse(1, 1, 1);
        i_ds3_line_model.pulse(4, 1, 1);
        rd_chk(`OFF_FAR_ERR_CNT, 8'h01, "cnt02_oof_parity");
        rd_chk(`OFF_PATH_PARITY_CNT, 8'h00, "cnt04_oof");
        i_ds3_line_model.set_fault(1'b0, 1'b0);
        rd_chk(`OFF_PATH_PARITY_CNT, 8'h00, "cnt04_after_oof");
        $display("test parity_mode done");
        do_reset;
        mode = 1'b1;
        rep0 = i_ds3_line_model.tx_reports;
        i_ds3_line_model.pulse(2, 2, 1);
        i_ds3_line_model.pulse(0, 4, 1);
        i_ds3_line_model.pulse(3, 1, 1);
        i_ds3_line_model.pulse(1, 1, 2);
        rd_chk(`OFF_FAR_ERR_CNT, 8'h02, "cnt02_legacy");
        rd_chk(`OFF_PARITY_FRAME_CNT, 8'h04, "cnt03_legacy");
        check("reports_legacy", i_ds3_line_model.tx_reports - rep0, 8'h02);
        i_ds3_line_model.set_fault(1'b1, 1'b0);
        i_ds3_line_model.pulse(2, 1, 1);
        i_ds3_line_model.pulse(0, 1, 1);
        i_ds3_line_model.pulse(4, 1, 2);
        rd_chk(`OFF_FAR_ERR_CNT, 8'h00, "cnt02_los");
        rd_chk(`OFF_PARITY_FRAME_CNT, 8'h00, "cnt03_los");
        rd_chk(`OFF_PATH_PARITY_CNT, 8'h00, "cnt04_los");
        i_ds3_line_model.set_fault(1'b0, 1'b0);
        rd_chk(`OFF_FAR_ERR_CNT, 8'h00, "cnt02_after_los");
        rd_chk(`OFF_PARITY_FRAME_CNT, 8'h00, "cnt03_after_los");
        do_reset;
        i_ds3_line_model.pulse(2, 260, 0);
        rd_chk(`OFF_FAR_ERR_CNT, 8'hff, "cnt02_saturated");
        $display("test legacy_mode done");
        do_reset;
        ten_rep = 1'b1;
        reg_wr(`OFF_ALARM_TX_CTRL, 8'hed);
        repeat (2) @(negedge clk_i);
        check("ext_enable", {7'h00, ext_en}, 8'h01);
        i_ds3_line_model.slots(16 * 12);
        check_words(6'h2d, 10, 12);
        rd_chk(`OFF_ALARM_TX_CTRL, 8'had, "ctrl05_selfclear");
        reg_wr(`OFF_ALARM_TX_CTRL, 8'hd2); // Second word of a two-word command
        repeat (2) @(negedge clk_i);
        i_ds3_line_model.slots(16 * 11);
        check_words(6'h12, 10, 11);
        // Extended mode off: the ten-repeat input no longer applies
        reg_wr(`OFF_ALARM_TX_CTRL, 8'h55);
        repeat (2) @(negedge clk_i);
        check("ext_disable", {7'h00, ext_en}, 8'h00);
        i_ds3_line_model.slots(16 * 3);
        reg_wr(`OFF_ALARM_TX_CTRL, 8'h15); // Cleared at a word boundary
        i_ds3_line_model.slots(16 * 12);
        check_words(6'h15, 13, 15);
        $display("test alarm_channel done");
        final_report;
    end
endmodule
`default_nettype wire
